// file: hw/ldr_consts.svh
// Port offsets, field positions and reset values of the legacy DMA register interface.
`ifndef LDR_CONSTS_SVH
`define LDR_CONSTS_SVH
`define LDR_P_C1_SMASK  8'h0a
`define LDR_P_C1_BPTR   8'h0c
`define LDR_P_C1_MCLR   8'h0d
`define LDR_P_C1_CMASK  8'h0e
`define LDR_P_C2_STAT   8'hd0
`define LDR_P_C2_CMD    8'hd0
`define LDR_P_C2_SREQ   8'hd2
`define LDR_P_C2_SMASK  8'hd4
`define LDR_P_C2_MODE   8'hd6
`define LDR_P_C2_BPTR   8'hd8
`define LDR_P_C2_MCLR   8'hda
`define LDR_P_C2_CMASK  8'hdc
`define LDR_P_C2_MASK   8'hde
`define LDR_P_C2_WORD   4'hc
`define LDR_CMD_MEM2MEM 0
`define LDR_CMD_HOLD    1
`define LDR_CMD_DIS     2
`define LDR_CMD_COMP    3
`define LDR_CMD_ROT     4
`define LDR_CMD_EXTWR   5
`define LDR_CMD_REQLOW  6
`define LDR_CMD_ACKHIGH 7
`define LDR_SEL_BIT     2
`define LDR_MASK_RST    4'hf
`define LDR_CMD_RST     8'h00
`define LDR_FIFO_DEPTH  4
`endif

// file: hw/ldr_pkg.sv
// Types shared by the legacy DMA register interface.
package ldr_pkg;
   typedef enum logic [1:0] {
      LDR_DEMAND  = 2'b00,
      LDR_SINGLE  = 2'b01,
      LDR_BLOCK   = 2'b10,
      LDR_CASCADE = 2'b11
   } ldr_mode_e;
   typedef enum logic [1:0] {
      LDR_VERIFY = 2'b00,
      LDR_WRITE  = 2'b01,
      LDR_READ   = 2'b10,
      LDR_RSVD   = 2'b11
   } ldr_xfer_e;
   typedef enum logic {
      LDR_IDLE = 1'b0,
      LDR_BUSY = 1'b1
   } ldr_state_e;
   typedef struct packed {
      ldr_mode_e mode;
      logic      dec;
      logic      auto_init;
      ldr_xfer_e kind;
   } ldr_chmode_s;
   typedef struct packed {
      logic [1:0] chan;
      ldr_xfer_e  kind;
      logic [15:0] addr;
      logic       last;
   } ldr_desc_s;
   typedef struct packed {
      logic compressed;
      logic ext_write;
      logic mem2mem;
   } ldr_timing_s;
endpackage

// file: hw/ldr_dma.sv
// Second controller DMA registers, command ports, channel engine and descriptor FIFO.
//
// Contract
// - Status bits 7:4 show pending requests, bits 3:0 terminal count, channels 7..4.
// - Mode bits 7:6 pick demand, single, block or cascade operation.
// - Mode bit 5 makes the address decrement, otherwise increment.
// - Mode bit 4 reloads current address and count from base at terminal count.
// - Mode bits 3:2 give transfer type; verify makes no strobes, 11 reserved.
// - Request port bits 1:0 pick channel, bit 2 sets or clears soft request.
// - Command bit 2 set disables the whole controller.
// - Command bit 4 selects rotating priority, otherwise fixed priority.
// - Command bit 7 sets acknowledge polarity, bit 6 request polarity.
// - Command bits 3,5,1,0 enable compressed, extended write, address hold, mem-to-mem.
// - Mask register bits 3:0 mask channels 7..4, one masks.
// - Single-mask port writes one mask bit chosen by bits 1:0, value bit 2.
// - Any write to clear-mask port unmasks all four channels, save one masked by its terminal count in that cycle.
// - Reading clear-mask port resets the mode readback counter.
// - Four mode port reads after that return channel modes in order.
// - Any write to master-clear port resets the registers, masking all; the descriptor FIFO keeps its entries.
// - Writing byte-pointer port clears the pointer, next access hits low byte.
// - Reading byte-pointer port sets the pointer, next access hits high byte.
// - In-progress flag sets on first request after unmask, clears at terminal count.
// - Reading mask port returns channel 4..7 mask bits in bits 0..3.
`timescale 1ns/1ps
`default_nettype none
`include "ldr_consts.svh"

module ldr_fifo #(
   parameter int W = 21,
   parameter int D = `LDR_FIFO_DEPTH
) (
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   cnt;
   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;
   assign in_ready  = (cnt != (AW+1)'(D));
   assign out_valid = (cnt != '0);
   assign out_data  = mem[rp];
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         if (push) begin
            wp <= (wp == AW'(D - 1)) ? '0 : AW'(wp + 1'b1);
         end
         if (pop) begin
            rp <= (rp == AW'(D - 1)) ? '0 : AW'(rp + 1'b1);
         end
         cnt <= (AW+1)'(cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      end
   end
endmodule

module ldr_dma (
   input  wire logic            clk_sys,
   input  wire logic            resetn,
   input  wire logic [7:0]      io_addr,
   input  wire logic            io_wr,
   input  wire logic            io_rd,
   input  wire logic [7:0]      io_wdata,
   output logic [7:0]           io_rdata,
   input  wire logic [3:0]      transfer_request,
   output logic [3:0]           transfer_acknowledge,
   output logic                 terminal_count,
   output logic [3:0]           ch_in_progress,
   output logic [3:0]           ctl1_mask,
   output logic                 ctl1_byte_pointer,
   output logic                 ctl2_byte_pointer,
   output var ldr_pkg::ldr_timing_s timing_cfg,
   output logic                 desc_valid,
   input  wire logic            desc_ready,
   output var ldr_pkg::ldr_desc_s desc
);
   logic [3:0] req_s1;
   logic [3:0] req_s2;
   logic [7:0] cmd;
   logic [3:0] mask;
   logic [3:0] next_mask;
   logic [3:0] tcf;
   logic [3:0] sreq;
   logic [3:0] armed;
   logic [1:0] rbc;
   logic [1:0] act;
   logic [1:0] last;
   logic [1:0] pick;
   logic [1:0] idx;
   logic       found;
   logic [7:0] last_wdata;
   ldr_pkg::ldr_state_e  state;
   ldr_pkg::ldr_chmode_s mode [4];
   logic [15:0] base_a [4];
   logic [15:0] cur_a  [4];
   logic [15:0] base_c [4];
   logic [15:0] cur_c  [4];
   logic       fifo_ready;
   ldr_pkg::ldr_desc_s push_desc;

   wire wr_hit_mclr = io_wr && io_addr == `LDR_P_C2_MCLR;
   wire word_hit    = io_addr[7:4] == `LDR_P_C2_WORD && !io_addr[0];
   wire word_acc    = word_hit && (io_wr || io_rd);
   wire [1:0] word_ch = io_addr[3:2];
   wire [3:0] req_live = req_s2 ^ {4{cmd[`LDR_CMD_REQLOW]}};
   wire [3:0] pending  = req_live | sreq;
   wire [3:0] want     = pending & ~mask;
   ldr_pkg::ldr_chmode_s am;
   assign am = mode[act];
   wire busy    = state == ldr_pkg::LDR_BUSY;
   wire cascade = am.mode == ldr_pkg::LDR_CASCADE;
   // Verify and the reserved code issue no strobes, so they need no FIFO room.
   wire no_strobe = am.kind == ldr_pkg::LDR_VERIFY || am.kind == ldr_pkg::LDR_RSVD;
   wire xfer = busy && !cascade && (no_strobe || fifo_ready);
   wire fin  = xfer && cur_c[act] == 16'h0000;
   wire [3:0] tc_evt = fin ? 4'(4'b0001 << act) : 4'h0;
   wire [3:0] auto_v = {mode[3].auto_init, mode[2].auto_init,
                        mode[1].auto_init, mode[0].auto_init};

   // Request pins come from peripherals outside this clock domain.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         req_s1 <= 4'h0;
         req_s2 <= 4'h0;
      end else begin
         req_s1 <= transfer_request;
         req_s2 <= req_s1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmd <= `LDR_CMD_RST;
      end else if (wr_hit_mclr) begin
         cmd <= `LDR_CMD_RST;
      end else if (io_wr && io_addr == `LDR_P_C2_CMD) begin
         cmd <= io_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         timing_cfg <= '0;
      end else begin
         timing_cfg.compressed <= cmd[`LDR_CMD_COMP];
         timing_cfg.ext_write  <= cmd[`LDR_CMD_EXTWR];
         timing_cfg.mem2mem    <= cmd[`LDR_CMD_MEM2MEM];
      end
   end

   // A terminal count that masks a channel wins over a software unmask.
   always_comb begin
      next_mask = mask;
      if (io_wr && io_addr == `LDR_P_C2_MASK) begin
         next_mask = io_wdata[3:0];
      end
      if (io_wr && io_addr == `LDR_P_C2_SMASK) begin
         next_mask[io_wdata[1:0]] = io_wdata[`LDR_SEL_BIT];
      end
      if (io_wr && io_addr == `LDR_P_C2_CMASK) begin
         next_mask = 4'h0;
      end
      next_mask = next_mask | (tc_evt & ~auto_v);
      if (wr_hit_mclr) begin
         next_mask = `LDR_MASK_RST;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mask <= `LDR_MASK_RST;
      end else begin
         mask <= next_mask;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tcf <= 4'h0;
      end else if (wr_hit_mclr) begin
         tcf <= 4'h0;
      end else if (io_rd && io_addr == `LDR_P_C2_STAT) begin
         tcf <= tc_evt;
      end else begin
         tcf <= tcf | tc_evt;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sreq <= 4'h0;
      end else if (wr_hit_mclr) begin
         sreq <= 4'h0;
      end else if (io_wr && io_addr == `LDR_P_C2_SREQ) begin
         sreq <= sreq & ~tc_evt;
         sreq[io_wdata[1:0]] <= io_wdata[`LDR_SEL_BIT];
      end else begin
         sreq <= sreq & ~tc_evt;
      end
   end

   // Armed marks a fresh unmask; only the first request after it counts.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         armed          <= 4'h0;
         ch_in_progress <= 4'h0;
      end else if (wr_hit_mclr) begin
         armed          <= 4'h0;
         ch_in_progress <= 4'h0;
      end else begin
         armed          <= (armed | (mask & ~next_mask)) & ~(armed & want);
         ch_in_progress <= (ch_in_progress & ~tc_evt) | (armed & want);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            mode[i] <= '0;
         end
      end else if (wr_hit_mclr) begin
         for (int i = 0; i < 4; i++) begin
            mode[i] <= '0;
         end
      end else if (io_wr && io_addr == `LDR_P_C2_MODE) begin
         mode[io_wdata[1:0]] <= ldr_pkg::ldr_chmode_s'(io_wdata[7:2]);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rbc <= 2'b00;
      end else if (wr_hit_mclr || (io_rd && io_addr == `LDR_P_C2_CMASK)) begin
         rbc <= 2'b00;
      end else if (io_rd && io_addr == `LDR_P_C2_MODE) begin
         rbc <= 2'(rbc + 2'b01);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctl2_byte_pointer <= 1'b0;
      end else if (wr_hit_mclr || (io_wr && io_addr == `LDR_P_C2_BPTR)) begin
         ctl2_byte_pointer <= 1'b0;
      end else if (io_rd && io_addr == `LDR_P_C2_BPTR) begin
         ctl2_byte_pointer <= 1'b1;
      end else if (word_acc) begin
         ctl2_byte_pointer <= !ctl2_byte_pointer;
      end
   end

   // First controller keeps only its mask and byte pointer here.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctl1_mask         <= `LDR_MASK_RST;
         ctl1_byte_pointer <= 1'b0;
      end else if (io_wr && io_addr == `LDR_P_C1_MCLR) begin
         ctl1_mask         <= `LDR_MASK_RST;
         ctl1_byte_pointer <= 1'b0;
      end else begin
         if (io_wr && io_addr == `LDR_P_C1_SMASK) begin
            ctl1_mask[io_wdata[1:0]] <= io_wdata[`LDR_SEL_BIT];
         end else if (io_wr && io_addr == `LDR_P_C1_CMASK) begin
            ctl1_mask <= 4'h0;
         end
         if (io_wr && io_addr == `LDR_P_C1_BPTR) begin
            ctl1_byte_pointer <= 1'b0;
         end else if (io_rd && io_addr == `LDR_P_C1_BPTR) begin
            ctl1_byte_pointer <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            base_a[i] <= 16'h0000;
            cur_a[i]  <= 16'h0000;
            base_c[i] <= 16'h0000;
            cur_c[i]  <= 16'h0000;
         end
      end else if (wr_hit_mclr) begin
         for (int i = 0; i < 4; i++) begin
            base_a[i] <= 16'h0000;
            cur_a[i]  <= 16'h0000;
            base_c[i] <= 16'h0000;
            cur_c[i]  <= 16'h0000;
         end
      end else begin
         if (xfer) begin
            if (fin && am.auto_init) begin
               cur_a[act] <= base_a[act];
               cur_c[act] <= base_c[act];
            end else begin
               cur_c[act] <= 16'(cur_c[act] - 16'h0001);
               if (!(act == 2'b00 && cmd[`LDR_CMD_HOLD])) begin
                  cur_a[act] <= am.dec ? 16'(cur_a[act] - 16'h0001)
                                       : 16'(cur_a[act] + 16'h0001);
               end
            end
         end
         // A software write lands after the engine update and so overrides it.
         if (io_wr && word_hit) begin
            if (io_addr[1]) begin
               if (ctl2_byte_pointer) begin
                  base_c[word_ch][15:8] <= io_wdata;
                  cur_c[word_ch][15:8]  <= io_wdata;
               end else begin
                  base_c[word_ch][7:0] <= io_wdata;
                  cur_c[word_ch][7:0]  <= io_wdata;
               end
            end else if (ctl2_byte_pointer) begin
               base_a[word_ch][15:8] <= io_wdata;
               cur_a[word_ch][15:8]  <= io_wdata;
            end else begin
               base_a[word_ch][7:0] <= io_wdata;
               cur_a[word_ch][7:0]  <= io_wdata;
            end
         end
      end
   end

   always_comb begin
      pick  = 2'b00;
      found = 1'b0;
      idx   = 2'b00;
      for (int i = 0; i < 4; i++) begin
         idx = cmd[`LDR_CMD_ROT] ? 2'(last + 2'(i) + 2'b01) : 2'(i);
         if (!found && want[idx]) begin
            pick  = idx;
            found = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= ldr_pkg::LDR_IDLE;
         act   <= 2'b00;
         last  <= 2'b11;
      end else if (wr_hit_mclr || cmd[`LDR_CMD_DIS]) begin
         state <= ldr_pkg::LDR_IDLE;
      end else begin
         case (state)
            ldr_pkg::LDR_IDLE: begin
               if (found) begin
                  state <= ldr_pkg::LDR_BUSY;
                  act   <= pick;
               end
            end
            ldr_pkg::LDR_BUSY: begin
               if (cascade) begin
                  if (!want[act]) begin
                     state <= ldr_pkg::LDR_IDLE;
                     last  <= act;
                  end
               end else if (xfer) begin
                  if (fin || am.mode == ldr_pkg::LDR_SINGLE ||
                      (am.mode == ldr_pkg::LDR_DEMAND && !pending[act])) begin
                     state <= ldr_pkg::LDR_IDLE;
                     last  <= act;
                  end
               end
            end
            default: begin
               state <= ldr_pkg::LDR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         transfer_acknowledge <= 4'hf;
         terminal_count       <= 1'b0;
      end else begin
         transfer_acknowledge <= (((busy && cascade && want[act]) || xfer) ?
                                  4'(4'b0001 << act) : 4'h0)
                                 ^ {4{!cmd[`LDR_CMD_ACKHIGH]}};
         terminal_count <= fin;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         if (io_addr == `LDR_P_C2_STAT) begin
            io_rdata <= {pending, tcf};
         end else if (io_addr == `LDR_P_C2_MODE) begin
            io_rdata <= {mode[rbc], rbc};
         end else if (io_addr == `LDR_P_C2_MASK) begin
            io_rdata <= {4'h0, mask};
         end else if (word_hit) begin
            io_rdata <= io_addr[1] ?
                        (ctl2_byte_pointer ? cur_c[word_ch][15:8] : cur_c[word_ch][7:0]) :
                        (ctl2_byte_pointer ? cur_a[word_ch][15:8] : cur_a[word_ch][7:0]);
         end else begin
            io_rdata <= 8'h00;
         end
      end
   end

   assign push_desc = '{chan: act, kind: am.kind, addr: cur_a[act], last: fin};

   ldr_fifo #(
      .W ($bits(ldr_pkg::ldr_desc_s)),
      .D (`LDR_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .in_valid  (xfer && !no_strobe),
      .in_ready  (fifo_ready),
      .in_data   (push_desc),
      .out_valid (desc_valid),
      .out_ready (desc_ready),
      .out_data  (desc)
   );

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         last_wdata <= 8'h00;
      end else begin
         last_wdata <= io_wdata;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   AST_MCLR: assert property (wr_hit_mclr |=> mask == 4'hf && cmd == 8'h00 && !busy)
      else $error("master clear did not reset the controller");
   AST_CMASK: assert property (io_wr && io_addr == 8'hdc && tc_evt == 4'h0 |=> mask == 4'h0)
      else $error("clear mask left a channel masked");
   AST_SMASK: assert property (io_wr && io_addr == 8'hd4 && tc_evt == 4'h0
      |=> mask[last_wdata[1:0]] == last_wdata[2])
      else $error("single mask bit not written");
   AST_BP_CLR: assert property (io_wr && io_addr == 8'hd8 |=> !ctl2_byte_pointer)
      else $error("byte pointer not cleared");
   AST_BP_SET: assert property (io_rd && io_addr == 8'hd8 |=> ctl2_byte_pointer)
      else $error("byte pointer not set");
   AST_BP_TOG: assert property (word_acc && !wr_hit_mclr
      |=> ctl2_byte_pointer != $past(ctl2_byte_pointer))
      else $error("byte pointer did not toggle");
   AST_RB: assert property (io_rd && io_addr == 8'hdc |=> rbc == 2'b00)
      else $error("mode readback did not restart at first channel");
   AST_TCF: assert property (io_rd && io_addr == 8'hd0 && tc_evt == 4'h0 |=> tcf == 4'h0)
      else $error("status read did not clear terminal count bits");
   AST_DIS: assert property (cmd[2] |=> !busy)
      else $error("disabled controller kept running");

   COV_TC: cover property (fin ##1 terminal_count);
   COV_CASCADE: cover property (busy && cascade ##1 busy && cascade);
   COV_FULL: cover property (busy && !no_strobe && !fifo_ready);
endmodule
`default_nettype wire

// file: verif/ldr_periph.sv
// Peripheral request pins and descriptor sink on the far side of the DMA block.
`timescale 1ns/1ps
`default_nettype none
module ldr_periph (
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic [3:0] req_on,
   input  wire logic       stall,
   input  wire logic [3:0] transfer_acknowledge,
   output logic [3:0]      transfer_request,
   output logic            desc_ready,
   output var int          ack_count
);
   // Requests are active high while the command register keeps its reset polarity.
   assign transfer_request = req_on;
   // The sink can stall so that the FIFO is seen to fill and refuse.
   assign desc_ready = ~stall;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ack_count <= 0;
      end else if (transfer_acknowledge != 4'hf) begin
         ack_count <= ack_count + 1;
      end
   end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the second controller register interface.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin err_count++; \
   $display("wrong value at %0t: %s", $time, m); end end
module testbench;
   logic       clk_sys = 1'b0;
   logic       resetn = 1'b0;
   logic [7:0] io_addr = 8'h00;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic [7:0] d;
   logic       io_wr = 1'b0;
   logic       io_rd = 1'b0;
   logic       stall = 1'b0;
   logic [3:0] req_on = 4'h0;
   logic [3:0] transfer_request;
   logic [3:0] transfer_acknowledge;
   logic [3:0] ch_in_progress;
   logic [3:0] ctl1_mask;
   logic       terminal_count;
   logic       ctl1_byte_pointer;
   logic       ctl2_byte_pointer;
   logic       desc_valid;
   logic       desc_ready;
   ldr_pkg::ldr_timing_s timing_cfg;
   ldr_pkg::ldr_desc_s   desc;
   int         err_count = 0;
   int         checks = 0;
   int         cycles = 0;
   int         ack_count;
   int         a0;

   ldr_dma ldr_dma_i (.clk_sys(clk_sys), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .transfer_request(transfer_request), .transfer_acknowledge(transfer_acknowledge),
      .terminal_count(terminal_count), .ch_in_progress(ch_in_progress), .ctl1_mask(ctl1_mask),
      .ctl1_byte_pointer(ctl1_byte_pointer), .ctl2_byte_pointer(ctl2_byte_pointer),
      .timing_cfg(timing_cfg), .desc_valid(desc_valid), .desc_ready(desc_ready), .desc(desc));
   ldr_periph ldr_periph_i (.clk_sys(clk_sys), .resetn(resetn), .req_on(req_on), .stall(stall),
      .transfer_acknowledge(transfer_acknowledge), .transfer_request(transfer_request),
      .desc_ready(desc_ready), .ack_count(ack_count));

   always #4 clk_sys = ~clk_sys;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // The whole sequence needs a few hundred cycles; the ceiling leaves ample margin.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      io_wr <= 1'b1;
      io_addr <= a;
      io_wdata <= v;
      @(posedge clk_sys);
      io_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      io_rd <= 1'b1;
      io_addr <= a;
      @(posedge clk_sys);
      io_rd <= 1'b0;
      tick();
      d = io_rdata;
   endtask
   task automatic wait_tc();
      for (int i = 0; i < 200 && terminal_count !== 1'b1; i++) tick();
      `CHK(terminal_count, 1'b1, "no terminal count")
   endtask
   task automatic done(input string n);
      $display("test %s finished", n);
   endtask
   function automatic logic [7:0] mv(input logic [1:0] c);
      return {c, c[0], c[1], c, c};
   endfunction

   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      tick();
      `CHK(transfer_acknowledge, 4'hf, "ack idle after reset")
      `CHK(ctl1_mask, 4'hf, "first mask reset")
      rd(8'hde); `CHK(d, 8'h0f, "mask reset")
      rd(8'hd0); `CHK(d, 8'h00, "status reset")
      rd(8'h55); `CHK(d, 8'h00, "unmapped read")
      done("reset");
      wr(8'hdc, 8'h5a); rd(8'hde); `CHK(d, 8'h00, "clear mask")
      wr(8'hd4, 8'h06); rd(8'hde); `CHK(d, 8'h04, "single mask set")
      wr(8'hd4, 8'h02); rd(8'hde); `CHK(d, 8'h00, "single mask clear")
      wr(8'h0e, 8'h00); wr(8'h0a, 8'h05); tick();
      `CHK(ctl1_mask, 4'h2, "first single mask")
      wr(8'h0d, 8'h00); tick(); `CHK(ctl1_mask, 4'hf, "first master clear")
      wr(8'hda, 8'h00); rd(8'hde); `CHK(d, 8'h0f, "master clear masks")
      wr(8'hde, 8'h0d); rd(8'hde); `CHK(d, 8'h0d, "mask write")
      done("masks");
      rd(8'hd8); `CHK(ctl2_byte_pointer, 1'b1, "pointer set")
      wr(8'hd8, 8'h00); tick(); `CHK(ctl2_byte_pointer, 1'b0, "pointer clear")
      rd(8'hc0); `CHK(ctl2_byte_pointer, 1'b1, "pointer toggle")
      rd(8'h0c); `CHK(ctl1_byte_pointer, 1'b1, "first pointer set")
      wr(8'h0c, 8'h00); tick(); `CHK(ctl1_byte_pointer, 1'b0, "first pointer clr")
      done("byte pointer");
      for (int k = 0; k < 4; k++) wr(8'hd6, mv(k[1:0]));
      rd(8'hdc);
      for (int k = 0; k < 4; k++) begin
         rd(8'hd6); `CHK(d, mv(k[1:0]), "mode readback")
      end
      done("modes");
      wr(8'hd0, 8'h04); wr(8'hd4, 8'h01); wr(8'hd2, 8'h05);
      rd(8'hd0); `CHK(d, 8'h20, "soft request pending")
      a0 = ack_count;
      tick(20); `CHK(ack_count, a0, "disabled controller")
      wr(8'hd0, 8'h00); wait_tc(); tick();
      `CHK(ack_count, a0 + 1, "single transfer")
      rd(8'hd0); `CHK(d, 8'h02, "status tc ch5")
      wr(8'hd0, 8'h21); tick(2); `CHK(timing_cfg, 3'b011, "timing bits")
      wr(8'hd0, 8'h80); tick(2); `CHK(transfer_acknowledge, 4'h0, "ack high")
      wr(8'hd0, 8'h00);
      done("command");
      wr(8'hd6, 8'ha4); wr(8'hd8, 8'h00); wr(8'hc0, 8'h20); wr(8'hc0, 8'h00);
      wr(8'hc2, 8'h05); wr(8'hc2, 8'h00);
      @(posedge clk_sys);
      stall <= 1'b1;
      tick(4);
      a0 = ack_count;
      wr(8'hd4, 8'h00);
      @(posedge clk_sys);
      req_on <= 4'h1;
      tick(40);
      `CHK(ack_count, a0 + 4, "FIFO full stalls")
      `CHK(desc.addr, 16'h0020, "first address")
      `CHK(desc.kind, ldr_pkg::LDR_WRITE, "write kind")
      `CHK(ch_in_progress, 4'h1, "in progress")
      @(posedge clk_sys);
      stall <= 1'b0;
      @(posedge clk_sys);
      stall <= 1'b1;
      tick(); `CHK(desc.addr, 16'h001f, "decrement")
      @(posedge clk_sys);
      stall <= 1'b0;
      wait_tc();
      @(posedge clk_sys);
      req_on <= 4'h0;
      tick(3);
      `CHK(ack_count, a0 + 6, "block count")
      `CHK(ch_in_progress, 4'h0, "progress cleared")
      rd(8'hd0); `CHK(d, 8'h01, "status tc ch4")
      rd(8'hd0); `CHK(d, 8'h00, "tc cleared by read")
      rd(8'hde); `CHK(d, 8'h0f, "masked at tc")
      done("transfer");
      rd(8'hd8); wr(8'hda, 8'h00); tick();
      `CHK(ctl2_byte_pointer, 1'b0, "clear resets pointer")
      rd(8'hdc); rd(8'hd6); `CHK(d, 8'h00, "clear resets modes")
      done("master clear");
      // Block verify with auto-init on channel 6: no descriptors, mask kept, count reloaded.
      wr(8'hd6, 8'h92); wr(8'hca, 8'h02); wr(8'hca, 8'h00); wr(8'hd4, 8'h02);
      a0 = ack_count;
      wr(8'hd2, 8'h06); wait_tc(); tick();
      `CHK(ack_count, a0 + 3, "verify block count")
      `CHK(desc_valid, 1'b0, "verify pushes nothing")
      rd(8'hde); `CHK(d, 8'h0b, "auto-init keeps mask")
      rd(8'hca); `CHK(d, 8'h02, "count reloaded")
      done("auto-init verify");
      print_verdict();
   end
endmodule
`default_nettype wire
